// ---- pkg/way_lock_pkg.sv ----
// package: constants for the way-lock and coupled-memory region block
package way_lock_pkg;
   // ****************************************************************
   // access selection
   // ****************************************************************
   localparam logic [3:0] SEL_WAY_LOCK = 4'h0;     // secondary selector for way-lock registers
   localparam logic [3:0] SEL_REGION = 4'h1;       // secondary selector for region registers
   localparam logic [2:0] VARIANT_DATA = 3'h0;     // variant picking the data side
   localparam logic [2:0] VARIANT_INSTR = 3'h1;    // variant picking the instruction side
   // ****************************************************************
   // field layouts and reset values
   // ****************************************************************
   localparam int NUM_WAYS = 4;                    // cache associativity
   localparam logic [3:0] LOCK_RESET = 4'h0;       // all ways open after reset
   localparam logic [11:0] LOCK_ONES = 12'hfff;    // bits 15:4 read as ones
   localparam logic [1:0] FILL_WAY_ALL_LOCKED = 2'h3; // fallback fill way
   localparam int BASE_LSB = 12;                   // base address low bit
   localparam int SIZE_LSB = 2;                    // size field low bit
   localparam logic [19:0] BASE_RESET = 20'h00000; // base after reset
   // ****************************************************************
   // size encoding bounds
   // ****************************************************************
   localparam logic [3:0] SIZE_MIN_CODE = 4'h3;    // 4KB
   localparam logic [3:0] SIZE_MAX_CODE = 4'hb;    // 1MB
   localparam int SIZE_SHIFT_BIAS = 9;             // code 3 -> 2^12 bytes
endpackage

// ---- design/fill_way_pick.sv ----
// fill-way selector honouring the lock bits of one cache
module fill_way_pick
   import way_lock_pkg::*;
(
   // lock state and replacement proposal
   input wire logic [3:0] i_lock,
   input wire logic [1:0] i_victim,
   // chosen way
   output logic [1:0] o_way
);
   import way_lock_pkg::*;

   // first open way at or after the proposed victim, fallback to way 3
   always_comb begin
      logic [1:0] cand;
      cand = i_victim;
      o_way = FILL_WAY_ALL_LOCKED;
      if (&i_lock) begin
         o_way = FILL_WAY_ALL_LOCKED;
      end else begin
         for (int k = NUM_WAYS - 1; k >= 0; k--) begin
            cand = 2'(i_victim + 2'(k));
            if (!i_lock[cand]) begin
               o_way = cand;
            end
         end
      end
   end
endmodule

// ---- design/way_lock_region.sv ----
// coprocessor registers for cache way locking and coupled-memory regions
// Behaviour
// - selector c0 way-lock, c1 region, others reserved
// - variant 0 data lock, 1 instruction lock
// - bit per way; set bit blocks allocation
// - all ways locked: fill goes to way 3
// - reset clears all lock bits
// - one instruction and one data region, 4KB minimum
// - region size comes from input pins
// - data region disabled at reset
// - instruction region enable follows boot pin
// - variant 0 data region, 1 instruction region
// - base 31:12, size 5:2 read-only, enable bit0
// - a region stops hitting one cycle after its enable bit clears
module way_lock_region
   import way_lock_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // coprocessor register access
   input wire logic i_access,
   input wire logic i_write,
   input wire logic [3:0] i_secondary_register_selector,
   input wire logic [2:0] i_variant,
   input wire logic [31:0] i_wdata,
   // configuration pins
   input wire logic [3:0] i_data_region_size_pins,
   input wire logic [3:0] i_instruction_region_size_pins,
   input wire logic i_boot_from_region_pin,
   // linefill requests
   input wire logic [1:0] i_dcache_victim,
   input wire logic [1:0] i_icache_victim,
   // address lookups
   input wire logic [31:0] i_data_addr,
   input wire logic [31:0] i_instr_addr,
   // register read answer
   output logic [31:0] o_rdata,
   output logic o_rvalid,
   output logic o_reserved_access,
   // fill ways
   output logic [1:0] o_dcache_fill_way,
   output logic [1:0] o_icache_fill_way,
   // region hits
   output logic o_data_region_hit,
   output logic o_instr_region_hit
);
   import way_lock_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [3:0] dlock;      // data cache lock bits
      logic [3:0] ilock;      // instruction cache lock bits
      logic [19:0] dbase;     // data region base
      logic [19:0] ibase;     // instruction region base
      logic den;              // data region enable
      logic ien;              // instruction region enable
      logic boot_pending;     // boot pin not yet sampled
      logic [31:0] rdata;     // read answer
      logic rvalid;           // read answer strobe
      logic reserved;         // reserved selector or variant strobe
      logic [1:0] dway;       // registered data fill way
      logic [1:0] iway;       // registered instruction fill way
      logic dhit;             // registered data hit
      logic ihit;             // registered instruction hit
   } state_t;

   state_t st;
   state_t next_st;
   logic [1:0] dway_comb;
   logic [1:0] iway_comb;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // lock register read image: ones in 15:4
   function automatic logic [31:0] lock_image(input logic [3:0] l);
      lock_image = {16'h0000, LOCK_ONES, l};
   endfunction

   // region register read image
   function automatic logic [31:0] region_image(input logic [19:0] b, input logic [3:0] sz, input logic en);
      region_image = {b, 6'h00, sz, 1'b0, en};
   endfunction

   // hit test; reserved or absent size codes never hit
   function automatic logic region_hit(input logic en, input logic [19:0] b, input logic [3:0] sz,
                                       input logic [31:0] a);
      logic [31:0] lo;
      logic [31:0] span;
      lo = {b, 12'h000};
      span = 32'h0;
      region_hit = 1'b0;
      if (en && sz >= SIZE_MIN_CODE && sz <= SIZE_MAX_CODE) begin
         // five bits: code 11 plus the bias reaches 20, which four bits would wrap
         span = 32'h1 << (5'(sz) + 5'(SIZE_SHIFT_BIAS));
         region_hit = (a >= lo) && ((a - lo) < span);
      end
   endfunction

   // ****************************************************************
   // fill way pickers
   // ****************************************************************
   fill_way_pick u_dpick (
      .i_lock(st.dlock),
      .i_victim(i_dcache_victim),
      .o_way(dway_comb)
   );

   fill_way_pick u_ipick (
      .i_lock(st.ilock),
      .i_victim(i_icache_victim),
      .o_way(iway_comb)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      next_st = st;
      next_st.rvalid = 1'b0;
      next_st.reserved = 1'b0;
      // boot pin caught on first clock after reset release
      if (st.boot_pending) begin
         next_st.boot_pending = 1'b0;
         next_st.ien = i_boot_from_region_pin;
      end
      if (i_access) begin
         unique case (i_secondary_register_selector)
            SEL_WAY_LOCK: begin
               // variant picks side; others act as reserved
               if (i_variant == VARIANT_DATA) begin
                  if (i_write) next_st.dlock = i_wdata[3:0];
                  else next_st.rdata = lock_image(st.dlock);
               end else if (i_variant == VARIANT_INSTR) begin
                  if (i_write) next_st.ilock = i_wdata[3:0];
                  else next_st.rdata = lock_image(st.ilock);
               end else begin
                  next_st.reserved = 1'b1;
               end
            end
            SEL_REGION: begin
               // size is never written; it mirrors the pins
               if (i_variant == VARIANT_DATA) begin
                  if (i_write) begin
                     next_st.dbase = i_wdata[31:BASE_LSB];
                     next_st.den = i_wdata[0];
                  end else begin
                     next_st.rdata = region_image(st.dbase, i_data_region_size_pins, st.den);
                  end
               end else if (i_variant == VARIANT_INSTR) begin
                  if (i_write) begin
                     next_st.ibase = i_wdata[31:BASE_LSB];
                     next_st.ien = i_wdata[0];
                     next_st.boot_pending = 1'b0;
                  end else begin
                     next_st.rdata = region_image(st.ibase, i_instruction_region_size_pins, st.ien);
                  end
               end else begin
                  next_st.reserved = 1'b1;
               end
            end
            default: begin
               next_st.reserved = 1'b1;
            end
         endcase
         next_st.rvalid = !i_write && !next_st.reserved;
         if (next_st.reserved) next_st.rdata = 32'h00000000;
      end
      // fill ways and hits registered for clean outputs
      next_st.dway = dway_comb;
      next_st.iway = iway_comb;
      next_st.dhit = region_hit(st.den, st.dbase, i_data_region_size_pins, i_data_addr);
      next_st.ihit = region_hit(st.ien, st.ibase, i_instruction_region_size_pins, i_instr_addr);
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st <= '0;
         st.dlock <= LOCK_RESET;
         st.ilock <= LOCK_RESET;
         st.dbase <= BASE_RESET;
         st.ibase <= BASE_RESET;
         st.den <= 1'b0;
         st.ien <= 1'b0;
         st.boot_pending <= 1'b1;
         st.dway <= FILL_WAY_ALL_LOCKED;
         st.iway <= FILL_WAY_ALL_LOCKED;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from flops
   assign o_rdata = st.rdata;
   assign o_rvalid = st.rvalid;
   assign o_reserved_access = st.reserved;
   assign o_dcache_fill_way = st.dway;
   assign o_icache_fill_way = st.iway;
   assign o_data_region_hit = st.dhit;
   assign o_instr_region_hit = st.ihit;
endmodule

// ---- verification/way_lock_region_monitor.sv ----
// checker: port relations of the way-lock and region block
module way_lock_region_monitor
   import way_lock_pkg::*;
(
   // clock, reset and access request
   input wire logic i_clk, i_rst, i_access, i_write,
   input wire logic [3:0] i_secondary_register_selector,
   input wire logic [2:0] i_variant,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_data_region_size_pins,
   // answers
   input wire logic [31:0] o_rdata,
   input wire logic o_rvalid, o_reserved_access, o_data_region_hit,
   input wire logic [1:0] o_dcache_fill_way
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire logic [3:0] sl = i_secondary_register_selector;
   wire logic ok_sel = sl == SEL_WAY_LOCK || sl == SEL_REGION;
   wire logic ok_var = i_variant == VARIANT_DATA || i_variant == VARIANT_INSTR;
   wire logic rd = i_access && !i_write;
   wire logic dlock_wr = i_access && i_write && sl == SEL_WAY_LOCK && i_variant == VARIANT_DATA;
   wire logic dreg_wr = i_access && i_write && sl == SEL_REGION && i_variant == VARIANT_DATA;
   // data lock written with a given pattern, then left alone a cycle
   sequence s_dlock(logic [3:0] v);
      dlock_wr && i_wdata[3:0] == v ##1 !dlock_wr;
   endsequence
   property p_rvalid; rd && ok_sel && ok_var |=> o_rvalid && !o_reserved_access; endproperty
   a_rvalid: assert property (p_rvalid) else $error("read not answered");
   property p_res_sel; i_access && !ok_sel |=> o_reserved_access && o_rdata == 32'h0; endproperty
   a_res_sel: assert property (p_res_sel) else $error("reserved selector accepted");
   property p_res_var; i_access && !ok_var |=> o_reserved_access; endproperty
   a_res_var: assert property (p_res_var) else $error("reserved variant accepted");
   property p_lock_fmt; rd && sl == SEL_WAY_LOCK && ok_var |=> o_rdata[15:4] == LOCK_ONES; endproperty
   a_lock_fmt: assert property (p_lock_fmt) else $error("lock read format");
   property p_size; rd && sl == SEL_REGION && i_variant == VARIANT_DATA
      |=> o_rdata[5:2] == $past(i_data_region_size_pins); endproperty
   a_size: assert property (p_size) else $error("size field not from pins");
   property p_all_lock; s_dlock(4'hf) |-> ##2 o_dcache_fill_way == FILL_WAY_ALL_LOCKED; endproperty
   a_all_lock: assert property (p_all_lock) else $error("all locked fill way");
   property p_one_open; s_dlock(4'he) |-> ##2 o_dcache_fill_way == 2'h0; endproperty
   a_one_open: assert property (p_one_open) else $error("locked way chosen");
   property p_off; dreg_wr && !i_wdata[0] |-> ##2 !o_data_region_hit; endproperty
   a_off: assert property (p_off) else $error("disabled region hit");
endmodule
bind way_lock_region way_lock_region_monitor i_way_lock_region_monitor (.i_clk, .i_rst, .i_access,
   .i_write, .i_secondary_register_selector, .i_variant, .i_wdata, .i_data_region_size_pins,
   .o_rdata, .o_rvalid, .o_reserved_access, .o_data_region_hit, .o_dcache_fill_way);

// ---- verification/core_model.sv ----
// partner: core side issuing coprocessor register accesses
module core_model
   import way_lock_pkg::*;
(
   // answers from the block
   input wire logic i_clk, i_rvalid, i_reserved,
   input wire logic [31:0] i_rdata,
   // access request
   output logic o_access, o_write,
   output logic [3:0] o_sel,
   output logic [2:0] o_variant,
   output logic [31:0] o_wdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_access = 1'b0; o_write = 1'b0; o_sel = 4'h5; o_variant = 3'h5; o_wdata = 32'ha5a5a5a5;
   end
   // one access held through its taking edge; released select, variant and data lines carry junk, not the old value; write keeps its value
   task automatic xfer(input logic w, input logic [3:0] s, input logic [2:0] v,
                       input logic [31:0] d, output logic [31:0] q, output logic [1:0] fl);
      @(posedge i_clk);
      #1;
      o_access = 1'b1; o_write = w; o_sel = s; o_variant = v; o_wdata = d;
      @(posedge i_clk);
      #1;
      q = i_rdata;
      fl = {i_reserved, i_rvalid};
      o_access = 1'b0; o_sel = ~s; o_variant = ~v; o_wdata = ~d;
   endtask
   // lock change only by read, modify, write back; nothing else runs, so no exception splits it
   task automatic rmw(input logic [2:0] v, input logic [3:0] set_m, input logic [3:0] clr_m);
      logic [31:0] q;
      logic [1:0] fl;
      xfer(1'b0, SEL_WAY_LOCK, v, 32'h0, q, fl);
      xfer(1'b1, SEL_WAY_LOCK, v, (q | {28'h0, set_m}) & ~{28'h0, clr_m}, q, fl);
   endtask
endmodule

// ---- verification/way_lock_region_tb.sv ----
// testbench: way-lock and region block driven through a core model
module way_lock_region_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import way_lock_pkg::*;
   logic clk, rst, acc, wr, boot, rvalid, resv, dhit, ihit;
   logic [3:0] sel, dsz, isz;
   logic [2:0] vsel;
   logic [31:0] wdata, daddr, iaddr, rdata, q;
   logic [1:0] dvic, ivic, dway, iway, fl;
   int fails = 0, tests_run = 0, cycles = 0;
   way_lock_region i_way_lock_region (.i_clk(clk), .i_rst(rst), .i_access(acc), .i_write(wr),
      .i_secondary_register_selector(sel), .i_variant(vsel), .i_wdata(wdata),
      .i_data_region_size_pins(dsz), .i_instruction_region_size_pins(isz),
      .i_boot_from_region_pin(boot), .i_dcache_victim(dvic), .i_icache_victim(ivic),
      .i_data_addr(daddr), .i_instr_addr(iaddr), .o_rdata(rdata), .o_rvalid(rvalid),
      .o_reserved_access(resv), .o_dcache_fill_way(dway), .o_icache_fill_way(iway),
      .o_data_region_hit(dhit), .o_instr_region_hit(ihit));
   core_model i_core_model (.i_clk(clk), .i_rvalid(rvalid), .i_reserved(resv), .i_rdata(rdata),
      .o_access(acc), .o_write(wr), .o_sel(sel), .o_variant(vsel), .o_wdata(wdata));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      if (fails == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic rd(input logic [3:0] s, input logic [2:0] v);
      i_core_model.xfer(1'b0, s, v, 32'h0, q, fl);
   endtask
   task automatic wt(input logic [3:0] s, input logic [2:0] v, input logic [31:0] d);
      i_core_model.xfer(1'b1, s, v, d, q, fl);
   endtask
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   // values left by reset on both sides
   task automatic t_reset;
      rd(4'h0, 3'h0); chk(q, 32'h0000fff0);
      rd(4'h0, 3'h1); chk(q, 32'h0000fff0);
      rd(4'h1, 3'h0); chk(q, 32'h0000000c);
      rd(4'h1, 3'h1); chk(q, 32'h00000011);
   endtask
   // lock patterns, fill-way choice, unlocking; all-locked breaks the three-way limit on purpose
   task automatic t_locks;
      i_core_model.rmw(3'h0, 4'h5, 4'h0); i_core_model.rmw(3'h1, 4'ha, 4'h0);
      rd(4'h0, 3'h0); chk(q, 32'h0000fff5);
      rd(4'h0, 3'h1); chk(q, 32'h0000fffa);
      tick(); chk({30'h0, iway}, 32'h2);
      i_core_model.rmw(3'h0, 4'ha, 4'h1); tick(); chk({30'h0, dway}, 32'h0);
      i_core_model.rmw(3'h0, 4'h1, 4'h0); tick(); chk({30'h0, dway}, 32'h3);
      i_core_model.rmw(3'h0, 4'h0, 4'h4); tick(); chk({30'h0, dway}, 32'h2);
   endtask
   // region registers, size pins, hits
   task automatic t_region;
      wt(4'h1, 3'h0, 32'h0001003d); rd(4'h1, 3'h0); chk(q, 32'h0001000d);
      daddr = 32'h00010ffc; tick(); chk({31'h0, dhit}, 32'h1);
      daddr = 32'h00011000; tick(); chk({31'h0, dhit}, 32'h0);
      wt(4'h1, 3'h0, 32'h00010000); daddr = 32'h00010ffc; tick(); tick(); chk({31'h0, dhit}, 32'h0);
      wt(4'h1, 3'h1, 32'h00020001); iaddr = 32'h00021ffc; tick(); tick(); chk({31'h0, ihit}, 32'h1);
      dsz = 4'h5; rd(4'h1, 3'h0); chk(q, 32'h00010014);
      rd(4'h1, 3'h1); chk(q, 32'h00020011);
   endtask
   // reserved selector and variant change nothing
   task automatic t_reserved;
      rd(4'h2, 3'h0); chk(q, 32'h0); chk({30'h0, fl}, 32'h2);
      wt(4'hf, 3'h0, 32'h0); chk({30'h0, fl}, 32'h2);
      wt(4'h0, 3'h2, 32'h0000ffff); rd(4'h0, 3'h0); chk(q, 32'h0000fffb);
   endtask
   // mid-run reset with boot pin low, then a large data region that needs a wide shift
   task automatic t_rerun;
      rst = 1'b1; boot = 1'b0; dsz = 4'h7;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      rd(4'h0, 3'h0); chk({30'h0, fl}, 32'h1);
      chk(q, 32'h0000fff0);
      rd(4'h1, 3'h1); chk(q, 32'h00000010);
      rd(4'h1, 3'h0); chk(q, 32'h0000001c);
      wt(4'h1, 3'h0, 32'h00040001); daddr = 32'h0004fffc; tick(); chk({31'h0, dhit}, 32'h1);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         give_verdict();
      end
   end
   initial begin
      rst = 1'b1; boot = 1'b1; dsz = 4'h3; isz = 4'h4; dvic = 2'h2; ivic = 2'h1;
      daddr = 32'h0; iaddr = 32'h0;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_locks();
      t_region();
      t_reserved();
      t_rerun();
      give_verdict();
   end
endmodule
